/* flpi_cfg.svh */
`ifndef FLPI_CFG_SVH
`define FLPI_CFG_SVH
// Operation
// - control word takes 32-bit or 8-bit writes; master uses the width given per field
// - fifo moves whole 32-bit words; spare bytes of a last word are padding
// - interface clock divides the system clock, ratio from two control bits
// - nand read and write strobes are timed by the divided clock
// - chip enable held asserted for the whole flash access
// - one 8-bit two-way bus carries commands, addresses and data
// - command-phase enable asserted while a command byte is on the bus
// - nand: address latch high for address bytes, low during data
// - and-type: same pin is output enable, asserted while reading data or status
// - nand read data taken at the read strobe's falling-edge phase
// - and-type strobe is a shift clock; data both ways synchronous to it
// - command, address and write data stable for capture on write strobe rise
// - ready/busy high means ready, low means busy
// - a sector is 512 data bytes plus a 16-byte control area
// - command mode gives command, address, size; sector mode moves whole sectors

// system clock rate
`define FLPI_CLK_MHZ 125
// busy may lag the last write strobe; do not look at ready/busy before this
`define FLPI_T_WB_NS 100
`define FLPI_T_WB_CYC ((`FLPI_T_WB_NS * `FLPI_CLK_MHZ + 999) / 1000)

// sector layout
`define FLPI_SECT_DATA 512
`define FLPI_SECT_CTRL 16
`define FLPI_SECT_BYTES (`FLPI_SECT_DATA + `FLPI_SECT_CTRL)

// control word fields
`define FLPI_CTL_FCK_BIT 0
`define FLPI_CTL_QT_BIT 1
`define FLPI_CTL_NAND_BIT 2
`define FLPI_CTL_RST 32'h00000004
`define FLPI_CTL_MASK 32'h00000007

// system clocks per strobe phase for each {quarter, divider} selection
`define FLPI_DIV_R0 5'h02
`define FLPI_DIV_R1 5'h04
`define FLPI_DIV_R2 5'h08
`define FLPI_DIV_R3 5'h10

// fifo shape
`define FLPI_FIFO_WIDTH 32
`define FLPI_FIFO_DEPTH 16
`endif

/* flpi_pkg.sv */
`include "flpi_cfg.svh"
package flpi_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        FLPI_ST_IDLE = 3'h0,
        FLPI_ST_CMD1 = 3'h1,
        FLPI_ST_ADDR = 3'h2,
        FLPI_ST_CMD2 = 3'h3,
        FLPI_ST_GUARD = 3'h4,
        FLPI_ST_WAIT = 3'h5,
        FLPI_ST_DATA = 3'h6,
        FLPI_ST_DONE = 3'h7
    } flpi_state_t;

    // phases of one byte on the flash bus
    typedef enum logic [1:0] {
        FLPI_PH_SETUP = 2'h0,
        FLPI_PH_LOW = 2'h1,
        FLPI_PH_HIGH = 2'h2
    } flpi_phase_t;

    typedef enum logic {
        FLPI_MODE_CMD = 1'h0,
        FLPI_MODE_SECT = 1'h1
    } flpi_mode_t;

    typedef enum logic {
        FLPI_DIR_WRITE = 1'h0,
        FLPI_DIR_READ = 1'h1
    } flpi_dir_t;
endpackage

/* flpi_fifo.sv */
module flpi_fifo
    import flpi_pkg::*;
#(
    parameter int WIDTH = `FLPI_FIFO_WIDTH,
    parameter int DEPTH = `FLPI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    logic push;
    logic load;

    // full counts only the array; the output register is one extra slot
    assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign load = (cnt_r != '0) && (!out_valid_r || out_ready);
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // storage, no reset needed on the array itself
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap naturally; depth must be a power of two
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // occupancy of the array
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (push && !load) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (load && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // registered read port
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (load) begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end
endmodule

/* flpi_top.sv */
module flpi_top
    import flpi_pkg::*;
#(
    parameter int LEN_W = 20,
    parameter int FIFO_DEPTH = `FLPI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control word access
    input wire logic ctl_wr,
    input wire logic ctl_wide,
    input wire logic [1:0] ctl_lane,
    input wire logic [31:0] ctl_wdata,
    output logic [31:0] ctl_rdata,
    // operation request
    input wire logic start_valid,
    output logic start_ready,
    input wire logic start_mode,
    input wire logic start_dir,
    input wire logic [7:0] start_cmd1,
    input wire logic [7:0] start_cmd2,
    input wire logic start_cmd2_en,
    input wire logic [39:0] start_addr,
    input wire logic [2:0] start_addr_bytes,
    input wire logic [15:0] start_size,
    input wire logic [7:0] start_sect_cnt,
    // operation status
    output logic op_busy,
    output logic op_done,
    // write data stream into the fifo
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [31:0] wr_data,
    // read data stream out of the fifo
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_data,
    // flash pins
    output logic flash_chip_enable_n,
    output logic command_phase_enable,
    output logic addr_or_output_enable,
    output logic read_strobe_or_shift_clock,
    output logic write_strobe_n,
    output logic [7:0] flash_data_bus_out,
    output logic flash_data_bus_oe,
    input wire logic [7:0] flash_data_bus_in,
    input wire logic ready_busy_input
);
    logic [31:0] ctl_r, word_r, fifo_in_data, fifo_out_data;
    logic [4:0] div_cnt_r, ratio;
    flpi_state_t state_r, state_nxt, after_addr;
    flpi_phase_t ph_r, ph_nxt;
    flpi_dir_t dir_r;
    logic [7:0] cmd1_r, cmd2_r, guard_r, dq_nxt;
    logic [39:0] addr_r;
    logic [2:0] addr_left_r;
    logic [LEN_W-1:0] remain_r, start_len;
    logic [1:0] lane_r;
    logic tick, nand_r, cmd2_en_r, word_vld_r, word_full_r, in_byte, is_rd, hold, step;
    logic byte_end, sample, last_in_word, done_r, eng_pop, eng_push, fifo_in_valid;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready, ce_n_nxt, cde_nxt, aoe_nxt;
    logic rsc_nxt, we_n_nxt, dq_oe_nxt;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl_r <= `FLPI_CTL_RST;
        end else if (ctl_wr && ctl_wide) begin
            ctl_r <= ctl_wdata & `FLPI_CTL_MASK;
        end else if (ctl_wr) begin
            ctl_r[ctl_lane*8 +: 8] <= ctl_wdata[ctl_lane*8 +: 8]
                & 8'(`FLPI_CTL_MASK >> (ctl_lane*8));
        end
    end
    assign ctl_rdata = ctl_r;

    // ratio chosen by the two select bits
    always_comb begin
        unique case ({ctl_r[`FLPI_CTL_QT_BIT], ctl_r[`FLPI_CTL_FCK_BIT]})
            2'h0: ratio = `FLPI_DIV_R0;
            2'h1: ratio = `FLPI_DIV_R1;
            2'h2: ratio = `FLPI_DIV_R2;
            2'h3: ratio = `FLPI_DIV_R3;
        endcase
    end

    // free-running divider; a ratio change lands at most one phase late
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
        end else if (tick) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end
    assign tick = (div_cnt_r >= ratio - 5'h01);

    // byte engine controls
    assign in_byte = (state_r == FLPI_ST_CMD1) || (state_r == FLPI_ST_ADDR)
        || (state_r == FLPI_ST_CMD2) || (state_r == FLPI_ST_DATA);
    assign is_rd = (dir_r == FLPI_DIR_READ);
    // stall only between bytes so a strobe never stretches mid-byte
    assign hold = (state_r == FLPI_ST_DATA) && (ph_r == FLPI_PH_SETUP)
        && (is_rd ? word_full_r : !word_vld_r);
    // every strobe phase advances on the divided tick
    assign step = tick && in_byte && !hold;
    assign byte_end = step && (ph_r == FLPI_PH_HIGH);
    // capture at the end of the low phase opened by the falling edge
    assign sample = step && (ph_r == FLPI_PH_LOW) && (state_r == FLPI_ST_DATA) && is_rd;
    assign last_in_word = (lane_r == 2'h3) || (remain_r == LEN_W'(1));

    // command mode size or whole sectors
    // sector length is data plus control area
    assign start_len = (start_mode == FLPI_MODE_SECT)
        ? LEN_W'(LEN_W'(start_sect_cnt) * LEN_W'(`FLPI_SECT_BYTES))
        : LEN_W'(start_size);

    // next phase of the current byte
    assign ph_nxt = (state_r == FLPI_ST_IDLE) ? FLPI_PH_SETUP : !step ? ph_r
        : (ph_r == FLPI_PH_SETUP) ? FLPI_PH_LOW
        : (ph_r == FLPI_PH_LOW) ? FLPI_PH_HIGH : FLPI_PH_SETUP;

    // where to go once the address bytes are out
    assign after_addr = (!is_rd && remain_r != '0) ? FLPI_ST_DATA
        : cmd2_en_r ? FLPI_ST_CMD2 : FLPI_ST_GUARD;

    // sequencer
    always_comb begin
        unique case (state_r)
            FLPI_ST_IDLE: state_nxt = start_valid ? FLPI_ST_CMD1 : state_r;
            FLPI_ST_CMD1: state_nxt = !byte_end ? state_r
                : (addr_left_r != '0) ? FLPI_ST_ADDR : after_addr;
            FLPI_ST_ADDR: state_nxt = (byte_end && addr_left_r == 3'h1) ? after_addr : state_r;
            FLPI_ST_CMD2: state_nxt = byte_end ? FLPI_ST_GUARD : state_r;
            FLPI_ST_GUARD: state_nxt = (guard_r == '0) ? FLPI_ST_WAIT : state_r;
            // hold until the flash reports ready
            FLPI_ST_WAIT: state_nxt = !ready_busy_input ? state_r
                : (remain_r != '0) ? FLPI_ST_DATA : FLPI_ST_DONE;
            FLPI_ST_DATA: state_nxt = !(byte_end && remain_r == LEN_W'(1)) ? state_r
                : is_rd ? FLPI_ST_DONE : cmd2_en_r ? FLPI_ST_CMD2 : FLPI_ST_GUARD;
            // the last read word must reach the fifo before finishing
            FLPI_ST_DONE: state_nxt = word_full_r ? state_r : FLPI_ST_IDLE;
        endcase
    end

    // state and phase registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= FLPI_ST_IDLE;
            ph_r <= FLPI_PH_SETUP;
        end else begin
            state_r <= state_nxt;
            ph_r <= ph_nxt;
        end
    end

    // request capture; the memory type is frozen for the whole operation
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            nand_r <= 1'b1;
            dir_r <= FLPI_DIR_WRITE;
            cmd1_r <= '0;
            cmd2_r <= '0;
            cmd2_en_r <= 1'b0;
        end else if (state_r == FLPI_ST_IDLE && start_valid) begin
            nand_r <= ctl_r[`FLPI_CTL_NAND_BIT];
            dir_r <= flpi_dir_t'(start_dir);
            cmd1_r <= start_cmd1;
            cmd2_r <= start_cmd2;
            cmd2_en_r <= start_cmd2_en;
        end
    end

    // address bytes leave low byte first
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_r <= '0;
            addr_left_r <= '0;
        end else if (state_r == FLPI_ST_IDLE && start_valid) begin
            addr_r <= start_addr;
            addr_left_r <= start_addr_bytes;
        end else if (state_r == FLPI_ST_ADDR && byte_end) begin
            addr_r <= {8'h00, addr_r[39:8]};
            addr_left_r <= addr_left_r - 3'h1;
        end
    end

    // bytes still to move and word lane
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            remain_r <= '0;
            lane_r <= '0;
        end else if (state_r == FLPI_ST_IDLE && start_valid) begin
            remain_r <= start_len;
            lane_r <= '0;
        end else if (state_r == FLPI_ST_DATA && byte_end) begin
            remain_r <= remain_r - LEN_W'(1);
            lane_r <= lane_r + 2'h1;
        end
    end

    // busy lags the strobe, so ready is ignored for a short guard
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            guard_r <= '0;
        end else if (state_r != FLPI_ST_GUARD) begin
            guard_r <= 8'(`FLPI_T_WB_CYC);
        end else if (guard_r != '0) begin
            guard_r <= guard_r - 8'h01;
        end
    end

    // engine side of the fifo follows the operation direction
    assign eng_pop = !is_rd && (state_r == FLPI_ST_DATA) && !word_vld_r && fifo_out_valid;
    assign eng_push = is_rd && word_full_r && fifo_in_ready;

    // words in and out; spare lanes of a last word are padding
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            word_r <= '0;
            word_vld_r <= 1'b0;
            word_full_r <= 1'b0;
        end else if (state_r == FLPI_ST_IDLE) begin
            word_r <= '0;
            word_vld_r <= 1'b0;
            word_full_r <= 1'b0;
        end else begin
            if (eng_pop) begin
                word_r <= fifo_out_data;
                word_vld_r <= 1'b1;
            end else if (eng_push) begin
                word_r <= '0;
            end else if (sample) begin
                word_r[lane_r*8 +: 8] <= flash_data_bus_in;
            end
            if (!is_rd && state_r == FLPI_ST_DATA && byte_end && last_in_word) begin
                word_vld_r <= 1'b0;
            end
            // a new full word outranks the push of the old one
            if (is_rd && state_r == FLPI_ST_DATA && byte_end && last_in_word) begin
                word_full_r <= 1'b1;
            end else if (eng_push) begin
                word_full_r <= 1'b0;
            end
        end
    end

    // fifo ports steered by direction
    assign fifo_in_valid = is_rd ? word_full_r : wr_valid;
    assign fifo_in_data = is_rd ? word_r : wr_data;
    assign fifo_out_ready = is_rd ? rd_ready : eng_pop;
    assign wr_ready = !is_rd && fifo_in_ready;
    assign rd_valid = is_rd && fifo_out_valid;
    assign rd_data = fifo_out_data;

    flpi_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // pin levels decoded from state and phase
    always_comb begin
        // selected from first command to end of operation
        ce_n_nxt = (state_nxt == FLPI_ST_IDLE) || (state_nxt == FLPI_ST_DONE);
        // command bytes for either memory type
        cde_nxt = (state_nxt == FLPI_ST_CMD1) || (state_nxt == FLPI_ST_CMD2);
        // nand address latch only for address bytes
        // and-type output enable, active low, for read data
        aoe_nxt = nand_r ? (state_nxt == FLPI_ST_ADDR)
            : !((state_nxt == FLPI_ST_DATA) && is_rd);
        // write strobe low then rising while the byte stays driven
        we_n_nxt = !((ph_nxt == FLPI_PH_LOW) && ((state_nxt != FLPI_ST_DATA && in_byte)
            || (state_nxt == FLPI_ST_DATA && nand_r && !is_rd)));
        // nand read strobe low through the read low phase
        // and-type shift clock rises for every data byte
        rsc_nxt = nand_r ? !(ph_nxt == FLPI_PH_LOW && state_nxt == FLPI_ST_DATA && is_rd)
            : (ph_nxt == FLPI_PH_HIGH && state_nxt == FLPI_ST_DATA);
        // shared bus for command, address and data
        dq_oe_nxt = cde_nxt || (state_nxt == FLPI_ST_ADDR)
            || (state_nxt == FLPI_ST_DATA && !is_rd);
        unique case (state_nxt)
            FLPI_ST_CMD1: dq_nxt = cmd1_r;
            FLPI_ST_ADDR: dq_nxt = (state_r == FLPI_ST_ADDR && byte_end)
                ? addr_r[15:8] : addr_r[7:0];
            FLPI_ST_CMD2: dq_nxt = cmd2_r;
            FLPI_ST_DATA: dq_nxt = word_r[lane_r*8 +: 8];
            FLPI_ST_IDLE, FLPI_ST_GUARD, FLPI_ST_WAIT, FLPI_ST_DONE: dq_nxt = 8'h00;
        endcase
    end

    // registered pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flash_chip_enable_n <= 1'b1;
            command_phase_enable <= 1'b0;
            addr_or_output_enable <= 1'b0;
            read_strobe_or_shift_clock <= 1'b1;
            write_strobe_n <= 1'b1;
            flash_data_bus_oe <= 1'b0;
            flash_data_bus_out <= 8'h00;
        end else begin
            flash_chip_enable_n <= ce_n_nxt;
            command_phase_enable <= cde_nxt;
            addr_or_output_enable <= aoe_nxt;
            read_strobe_or_shift_clock <= rsc_nxt;
            write_strobe_n <= we_n_nxt;
            flash_data_bus_oe <= dq_oe_nxt;
            flash_data_bus_out <= dq_nxt;
        end
    end

    // completion pulse
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == FLPI_ST_DONE) && !word_full_r;
        end
    end
    assign op_done = done_r;
    assign op_busy = (state_r != FLPI_ST_IDLE);
    assign start_ready = (state_r == FLPI_ST_IDLE);
endmodule

/* flpi_flash_model.sv */
module flpi_flash_model #(
    parameter int BUSY = 40
) (
    // clock
    input wire logic clk_sys,
    // controller pins
    input wire logic ce_n,
    input wire logic cmd_en,
    input wire logic addr_en,
    input wire logic re_n,
    input wire logic we_n,
    input wire logic [7:0] dq_wire,
    // driven back
    output logic [7:0] dq_drv,
    output logic rb
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] log_b [0:127];
    logic [1:0] log_k [0:127];
    int n = 0;
    int idx = 0;
    int bcnt = 0;
    logic we_q = 1'b1;
    logic re_q = 1'b1;
    // byte shown while strobe low, inverse once released
    assign dq_drv = re_n ? ~(8'ha0 + idx[7:0]) : 8'ha0 + idx[7:0];
    // busy window opens a few cycles after a confirm command
    assign rb = !(bcnt > 0 && bcnt <= BUSY);
    // capture on write strobe rise while selected
    always @(posedge clk_sys) begin
        we_q <= we_n;
        re_q <= re_n;
        if (bcnt > 0) begin
            bcnt <= bcnt - 1;
        end
        if (!we_q && we_n && !ce_n) begin
            log_b[n] <= dq_wire;
            log_k[n] <= {addr_en, cmd_en};
            n <= n + 1;
            if (cmd_en) begin
                idx <= 0;
            end
            if (cmd_en && (dq_wire == 8'h10 || dq_wire == 8'h30 || dq_wire == 8'hd0)) begin
                bcnt <= BUSY + 4;
            end
        end
        if (!re_q && re_n) begin
            idx <= idx + 1;
        end
    end
endmodule

/* flpi_top_checker.sv */
module flpi_top_checker
    import flpi_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control and request
    input wire logic ctl_wr,
    input wire logic ctl_wide,
    input wire logic [31:0] ctl_wdata,
    input wire logic [31:0] ctl_rdata,
    input wire logic start_valid,
    input wire logic start_ready,
    input wire logic op_busy,
    // flash pins
    input wire logic flash_chip_enable_n,
    input wire logic command_phase_enable,
    input wire logic addr_or_output_enable,
    input wire logic read_strobe_or_shift_clock,
    input wire logic write_strobe_n,
    input wire logic [7:0] flash_data_bus_out,
    input wire logic flash_data_bus_oe,
    input wire logic ready_busy_input
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // strobe low then its rise
    sequence s_we_rise;
        !write_strobe_n ##1 write_strobe_n;
    endsequence
    property p_ctl_wide;
        ctl_wr && ctl_wide |=> ctl_rdata == ($past(ctl_wdata) & 32'h00000007);
    endproperty
    a_ctl_wide: assert property (p_ctl_wide) else $error("control word wrong");
    property p_start;
        start_valid && start_ready |=> op_busy && !start_ready;
    endproperty
    a_start: assert property (p_start) else $error("request not taken");
    property p_ce_strobe;
        !write_strobe_n || (ctl_rdata[2] && !read_strobe_or_shift_clock) |-> !flash_chip_enable_n;
    endproperty
    a_ce_strobe: assert property (p_ce_strobe) else $error("strobe without select");
    property p_idle_pins;
        start_ready && $past(start_ready) |-> flash_chip_enable_n && write_strobe_n;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("select while idle");
    property p_cmd_bus;
        command_phase_enable && !write_strobe_n |-> flash_data_bus_oe;
    endproperty
    a_cmd_bus: assert property (p_cmd_bus) else $error("command not driven");
    property p_cde_ale;
        ctl_rdata[2] |-> !(command_phase_enable && addr_or_output_enable);
    endproperty
    a_cde_ale: assert property (p_cde_ale) else $error("command and address overlap");
    property p_ale_data;
        ctl_rdata[2] && !read_strobe_or_shift_clock |->
            !addr_or_output_enable && !command_phase_enable && !flash_data_bus_oe;
    endproperty
    a_ale_data: assert property (p_ale_data) else $error("read phase pins wrong");
    property p_we_hold;
        s_we_rise |-> $stable(flash_data_bus_out) && flash_data_bus_oe;
    endproperty
    a_we_hold: assert property (p_we_hold) else $error("data moved at strobe rise");
    property p_busy_quiet;
        !ready_busy_input |-> write_strobe_n && (read_strobe_or_shift_clock == ctl_rdata[2]);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while busy");
endmodule

/* flpi_top_bench.sv */
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("MISMATCH at %0t: got %h expected %h", $time, g, e); \
    end \
end
module flpi_top_bench;
    import flpi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    int compares = 0;
    int bad_count = 0;
    logic clk_sys = 0, rst_n = 0, ctl_wr = 0, ctl_wide = 0, start_valid = 0, start_mode = 0;
    logic start_dir = 0, start_cmd2_en = 1, wr_valid = 0, rd_ready = 1;
    logic [1:0] ctl_lane = 0;
    logic [31:0] ctl_wdata = 0, wr_data = 0;
    logic [7:0] start_cmd1 = 0, start_cmd2 = 0, start_sect_cnt = 0;
    logic [39:0] start_addr = 0;
    logic [2:0] start_addr_bytes = 0;
    logic [15:0] start_size = 0;
    logic [31:0] ctl_rdata, rd_data;
    logic start_ready, op_busy, op_done, wr_ready, rd_valid, ready_busy_input;
    logic flash_chip_enable_n, command_phase_enable, addr_or_output_enable;
    logic read_strobe_or_shift_clock, write_strobe_n, flash_data_bus_oe;
    logic [7:0] flash_data_bus_out, flash_data_bus_in, mem_drv;
    logic [31:0] rq[$];
    flpi_top i_dut (.clk_sys, .rst_n, .ctl_wr, .ctl_wide, .ctl_lane, .ctl_wdata, .ctl_rdata,
        .start_valid, .start_ready, .start_mode, .start_dir, .start_cmd1, .start_cmd2,
        .start_cmd2_en, .start_addr, .start_addr_bytes, .start_size, .start_sect_cnt,
        .op_busy, .op_done, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data,
        .flash_chip_enable_n, .command_phase_enable, .addr_or_output_enable,
        .read_strobe_or_shift_clock, .write_strobe_n, .flash_data_bus_out,
        .flash_data_bus_oe, .flash_data_bus_in, .ready_busy_input);
    flpi_flash_model i_mem (.clk_sys, .ce_n(flash_chip_enable_n), .cmd_en(command_phase_enable),
        .addr_en(addr_or_output_enable), .re_n(read_strobe_or_shift_clock),
        .we_n(write_strobe_n), .dq_wire(flash_data_bus_in), .dq_drv(mem_drv),
        .rb(ready_busy_input));
    // shared data wire: whoever enables drives it
    assign flash_data_bus_in = flash_data_bus_oe ? flash_data_bus_out : mem_drv;
    always #4 clk_sys = ~clk_sys;
    // collect read words as they leave
    always @(posedge clk_sys) begin
        if (rd_valid && rd_ready) begin
            rq.push_back(rd_data);
        end
    end
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic ctl(input logic wide, input logic [1:0] lane, input logic [31:0] d);
        ctl_wr = 1;
        ctl_wide = wide;
        ctl_lane = lane;
        ctl_wdata = d;
        tick();
        ctl_wr = 0;
        tick();
    endtask
    task automatic go(input logic dir, input logic [7:0] c1, c2, input logic [39:0] a,
            input logic [2:0] nb, input logic [15:0] sz);
        start_dir = dir;
        start_cmd1 = c1;
        start_cmd2 = c2;
        start_addr = a;
        start_addr_bytes = nb;
        start_size = sz;
        start_valid = 1;
        tick();
        start_valid = 0;
    endtask
    // bounded wait; running out ends the run
    task automatic wait_done();
        for (int i = 0; i < 20000 && op_done !== 1'b1; i++) tick();
        if (op_done !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic t_ctl();
        ctl(1, 0, 32'hfffffff7);
        `CHK(ctl_rdata, 32'h00000007);
        ctl(0, 1, 32'h0000ff00);
        `CHK(ctl_rdata, 32'h00000007);
        ctl(0, 0, 32'h00000004);
        `CHK(ctl_rdata, 32'h00000004);
        $display("control word test done");
    endtask
    task automatic t_write();
        int w, b;
        b = i_mem.n;
        wr_valid = 1;
        for (w = 0; w < 40 && wr_ready; w++) begin
            wr_data = {8'(4 * w + 3), 8'(4 * w + 2), 8'(4 * w + 1), 8'(4 * w)};
            tick();
        end
        wr_valid = 0;
        `CHK(w, 17);
        go(0, 8'h80, 8'h10, 40'h3412, 2, 66);
        wait_done();
        `CHK(i_mem.n - b, 70);
        `CHK({i_mem.log_k[b], i_mem.log_b[b]}, 10'h180);
        `CHK({i_mem.log_k[b+1], i_mem.log_b[b+1], i_mem.log_k[b+2], i_mem.log_b[b+2]}, 20'h84a34);
        for (w = 0; w < 66; w++) begin
            `CHK({i_mem.log_k[b+3+w], i_mem.log_b[b+3+w]}, {2'b00, 8'(w)});
        end
        `CHK({i_mem.log_k[b+69], i_mem.log_b[b+69]}, 10'h110);
        `CHK(i_mem.bcnt, 0);
        $display("program test done");
    endtask
    task automatic t_read();
        rq.delete();
        go(1, 8'h00, 8'h30, 40'h0, 4, 5);
        wait_done();
        repeat (4) tick();
        `CHK(rq.size(), 2);
        `CHK(rq[0], 32'ha3a2a1a0);
        `CHK(rq[1], 32'h000000a4);
        start_mode = 1;
        start_sect_cnt = 1;
        go(1, 8'h00, 8'h30, 40'h0, 4, 0);
        start_mode = 0;
        wait_done();
        repeat (4) tick();
        `CHK(rq.size(), 134);
        `CHK(rq[133], 32'hafaeadac);
        $display("read test done");
    endtask
    task automatic t_erase();
        int c, b;
        ctl(1, 0, 32'h00000003);
        b = i_mem.n;
        go(0, 8'h60, 8'hd0, 40'h563412, 3, 0);
        for (c = 0; c < 200 && write_strobe_n; c++) tick();
        for (c = 0; c < 200 && !write_strobe_n; c++) tick();
        `CHK(c, 16);
        wait_done();
        `CHK(i_mem.n - b, 5);
        `CHK(i_mem.log_b[b+4], 8'hd0);
        `CHK(i_mem.bcnt, 0);
        $display("erase test done");
    endtask
    initial begin
        repeat (8) tick();
        `CHK(ctl_rdata, 32'h00000004);
        `CHK({start_ready, op_busy, flash_chip_enable_n, write_strobe_n}, 4'hb);
        `CHK({read_strobe_or_shift_clock, flash_data_bus_oe, ready_busy_input}, 3'h5);
        rst_n = 1;
        t_ctl();
        t_write();
        t_read();
        t_erase();
        test_done();
    end
endmodule
bind flpi_top flpi_top_checker i_chk (.clk_sys, .rst_n, .ctl_wr, .ctl_wide, .ctl_wdata,
    .ctl_rdata, .start_valid, .start_ready, .op_busy, .flash_chip_enable_n,
    .command_phase_enable, .addr_or_output_enable, .read_strobe_or_shift_clock,
    .write_strobe_n, .flash_data_bus_out, .flash_data_bus_oe, .ready_busy_input);
